// >>> fpir_pkg.sv
package fpir_pkg;

  // Register byte offsets within the block
  localparam logic [11:0] OFS_CTX_PTR = 12'h000;
  localparam logic [11:0] OFS_DFLT_STAT = 12'h004;
  localparam logic [11:0] OFS_GROUP_INFO = 12'h008;
  localparam logic [11:0] OFS_AUX_CTRL = 12'h00C;
  localparam logic [11:0] OFS_IRQ_TRIG = 12'h010;

  // Field positions
  localparam int CTX_ADDR_LSB = 3;
  localparam int DS_AHP_BIT = 26;
  localparam int DS_DN_BIT = 25;
  localparam int DS_FZ_BIT = 24;
  localparam int DS_RM_LSB = 22;
  localparam int GRP_W = 4;
  localparam int TRIG_W = 9;
  localparam int LINES_PER_GROUP = 32;
  localparam int MAX_IRQS = 496;

  // Reset values
  localparam logic [28:0] CTX_ADDR_RST = 29'h0000_0000;
  localparam logic [31:0] AUX_RST = 32'h0000_0000;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Default floating-point mode fields
  typedef struct packed {
    logic alt_half_precision;
    logic default_nan_enable;
    logic flush_to_zero;
    logic [1:0] rounding_select;
  } fpir_fp_modes_t;

  // Pulse request to the pending logic
  typedef struct packed {
    logic valid;
    logic [TRIG_W-1:0] irq_number_field;
  } fpir_pend_t;

  // Whole block state
  typedef struct packed {
    logic aw_held;
    logic [11:0] aw_addr;
    logic aw_priv;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [28:0] ctx_addr;
    fpir_fp_modes_t dflt;
    logic [31:0] aux;
    fpir_pend_t pend;
    fpir_fp_modes_t fpsc;
  } fpir_state_t;

endpackage : fpir_pkg

// >>> fpir_sysregs.sv
`timescale 1ns/1ps
// Behaviour
// - Context pointer keeps bits 31..3, low RAZ/WI
// - Pointer and defaults need privileged access
// - Without FP, both locations are reserved
// - New FP context loads defaults into status
// - Defaults: half-precision 26, NaN 25, flush 24
// - Rounding default 23..22, rest reserved
// - Group count in bits 3..0
// - Total interrupts never exceed 496
// - Group count matches implemented controller registers
// - Auxiliary control always present, implementation defined
// - Trigger write sets pending like set-pending
// - Trigger acts on implemented lines only
module fpir_sysregs #(
  parameter bit FP_PRESENT = 1'b1,
  parameter int NUM_IRQ = 64
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic new_fp_context_in,
  output fpir_pkg::fpir_fp_modes_t fp_status_control_out,
  output fpir_pkg::fpir_pend_t pend_req_out,
  output logic [31:0] auxiliary_control_out
);

  // Group count derived from line count, capped at the all-ones code
  localparam int GRP_RAW = (NUM_IRQ + fpir_pkg::LINES_PER_GROUP - 1)
    / fpir_pkg::LINES_PER_GROUP - 1;
  localparam int NUM_IRQ_CAP = (NUM_IRQ > fpir_pkg::MAX_IRQS) ? fpir_pkg::MAX_IRQS
    : NUM_IRQ;
  localparam logic [fpir_pkg::GRP_W-1:0] IRQ_GROUP_COUNT =
    fpir_pkg::GRP_W'((GRP_RAW < 0) ? 0 : ((GRP_RAW > 15) ? 15 : GRP_RAW));

  fpir_pkg::fpir_state_t st_ff;
  fpir_pkg::fpir_state_t nxt_st;

  // Apply byte enables to a stored word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Address decode: 1 when the location answers as a working register
  function automatic logic reg_live(input logic [11:0] addr, input logic priv);
    logic ok;
    ok = 1'b0;
    unique case (addr)
      fpir_pkg::OFS_CTX_PTR, fpir_pkg::OFS_DFLT_STAT:
        ok = FP_PRESENT && priv;
      fpir_pkg::OFS_GROUP_INFO, fpir_pkg::OFS_AUX_CTRL, fpir_pkg::OFS_IRQ_TRIG:
        ok = 1'b1;
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction : reg_live

  // Pack default modes into their register image
  function automatic logic [31:0] dflt_word(input fpir_pkg::fpir_fp_modes_t m);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[fpir_pkg::DS_AHP_BIT] = m.alt_half_precision;
    w[fpir_pkg::DS_DN_BIT] = m.default_nan_enable;
    w[fpir_pkg::DS_FZ_BIT] = m.flush_to_zero;
    w[fpir_pkg::DS_RM_LSB +: 2] = m.rounding_select;
    return w;
  endfunction : dflt_word

  // Handshake outputs combinational; a channel opens only while its slot is free
  assign s_axi_awready_out = !st_ff.aw_held && !st_ff.bvalid;
  assign s_axi_wready_out = !st_ff.w_held && !st_ff.bvalid;
  assign s_axi_arready_out = !st_ff.rvalid;
  assign s_axi_bvalid_out = st_ff.bvalid;
  assign s_axi_bresp_out = st_ff.bresp;
  assign s_axi_rvalid_out = st_ff.rvalid;
  assign s_axi_rresp_out = st_ff.rresp;
  assign s_axi_rdata_out = st_ff.rdata;
  assign fp_status_control_out = st_ff.fpsc;
  assign pend_req_out = st_ff.pend;
  assign auxiliary_control_out = st_ff.aux;

  // Next-state logic for bus slave and registers
  always_comb
  begin
    logic [31:0] wv;
    logic [31:0] cur;
    logic live;
    logic [fpir_pkg::TRIG_W-1:0] num;
    wv = 32'h0000_0000;
    cur = 32'h0000_0000;
    live = 1'b0;
    num = '0;
    nxt_st = st_ff;
    nxt_st.pend.valid = 1'b0;

    // Capture address and data in either order
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr_in;
      nxt_st.aw_priv = s_axi_awprot_in[0];
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata_in;
      nxt_st.w_strb = s_axi_wstrb_in;
    end

    // Perform write once both halves are held
    if (st_ff.aw_held && st_ff.w_held)
    begin
      live = reg_live({st_ff.aw_addr[11:2], 2'b00}, st_ff.aw_priv);
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = live ? fpir_pkg::RESP_OKAY : fpir_pkg::RESP_SLVERR;
      if (live)
      begin
        unique case ({st_ff.aw_addr[11:2], 2'b00})
          fpir_pkg::OFS_CTX_PTR:
          begin
            cur = {st_ff.ctx_addr, 3'b000};
            wv = merge_bytes(cur, st_ff.w_data, st_ff.w_strb);
            nxt_st.ctx_addr = wv[31:fpir_pkg::CTX_ADDR_LSB];
          end
          fpir_pkg::OFS_DFLT_STAT:
          begin
            wv = merge_bytes(dflt_word(st_ff.dflt), st_ff.w_data, st_ff.w_strb);
            nxt_st.dflt.alt_half_precision = wv[fpir_pkg::DS_AHP_BIT];
            nxt_st.dflt.default_nan_enable = wv[fpir_pkg::DS_DN_BIT];
            nxt_st.dflt.flush_to_zero = wv[fpir_pkg::DS_FZ_BIT];
            nxt_st.dflt.rounding_select = wv[fpir_pkg::DS_RM_LSB +: 2];
          end
          fpir_pkg::OFS_AUX_CTRL:
            nxt_st.aux = merge_bytes(st_ff.aux, st_ff.w_data, st_ff.w_strb);
          fpir_pkg::OFS_IRQ_TRIG:
          begin
            // Only the low byte lanes carry the number; partial strobes keep zeros
            num = fpir_pkg::TRIG_W'(merge_bytes(32'h0000_0000, st_ff.w_data,
              st_ff.w_strb));
            if (32'(num) < NUM_IRQ_CAP)
            begin
              nxt_st.pend.valid = 1'b1;
              nxt_st.pend.irq_number_field = num;
            end
          end
          default:
            nxt_st.bresp = fpir_pkg::RESP_OKAY; // Group info is read-only
        endcase
      end
    end
    if (st_ff.bvalid && s_axi_bready_in)
    begin
      nxt_st.bvalid = 1'b0;
    end

    // Read path; trigger register reads as zero
    if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      live = reg_live({s_axi_araddr_in[11:2], 2'b00}, s_axi_arprot_in[0]);
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = live ? fpir_pkg::RESP_OKAY : fpir_pkg::RESP_SLVERR;
      nxt_st.rdata = 32'h0000_0000;
      if (live)
      begin
        unique case ({s_axi_araddr_in[11:2], 2'b00})
          fpir_pkg::OFS_CTX_PTR:
            nxt_st.rdata = {st_ff.ctx_addr, 3'b000};
          fpir_pkg::OFS_DFLT_STAT:
            nxt_st.rdata = dflt_word(st_ff.dflt);
          fpir_pkg::OFS_GROUP_INFO:
            nxt_st.rdata = {28'h000_0000, IRQ_GROUP_COUNT};
          fpir_pkg::OFS_AUX_CTRL:
            nxt_st.rdata = st_ff.aux;
          default:
            nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    else if (st_ff.rvalid && s_axi_rready_in)
    begin
      nxt_st.rvalid = 1'b0;
    end

    // New context copies the defaults; defaults written in this cycle apply next time
    if (new_fp_context_in && FP_PRESENT)
    begin
      nxt_st.fpsc = st_ff.dflt;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      st_ff <= '0;
      st_ff.ctx_addr <= fpir_pkg::CTX_ADDR_RST;
      st_ff.aux <= fpir_pkg::AUX_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule : fpir_sysregs

// >>> fpir_properties.sv
`timescale 1ns/1ps
// Judges read data, status loads and trigger pulses
module fpir_props #(parameter int NUM_IRQ = 64) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_bvalid_out,
  input wire logic new_fp_context_in,
  input wire fpir_pkg::fpir_fp_modes_t fp_status_control_out,
  input wire fpir_pkg::fpir_pend_t pend_req_out
);
  localparam int GRP = (NUM_IRQ + 31) / 32 - 1;
  logic [9:0] ra_ff;
  wire ar_go = s_axi_arvalid_in && s_axi_arready_out;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // Word index of the read in flight, since data comes a cycle later
  always_ff @(posedge clk_sys_in)
  begin
    if (ar_go)
    begin
      ra_ff <= s_axi_araddr_in[11:2];
    end
  end
  chk_ctx_low_bits:
  assert property (s_axi_rvalid_out && ra_ff == 10'h000 |-> s_axi_rdata_out[2:0] == 3'h0)
    else $error("ctx low bits set");
  chk_dflt_reserved:
  assert property (s_axi_rvalid_out && ra_ff == 10'h001 |-> s_axi_rdata_out[31:27] == 5'h00
    && s_axi_rdata_out[21:0] == 22'h0) else $error("defaults reserved bits set");
  chk_group_count:
  assert property (s_axi_rvalid_out && ra_ff == 10'h002 |-> s_axi_rdata_out == 32'(GRP))
    else $error("group count wrong");
  chk_unpriv_refused:
  assert property (ar_go && !s_axi_arprot_in[0] && s_axi_araddr_in[11:3] == 9'h000
    |=> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0) else $error("unprivileged read");
  chk_status_hold:
  assert property (!new_fp_context_in |=> $stable(fp_status_control_out))
    else $error("status moved without new context");
  chk_pend_with_resp:
  assert property (pend_req_out.valid |-> $rose(s_axi_bvalid_out)) else $error("pend off resp");
  chk_pend_one_cycle:
  assert property (pend_req_out.valid |=> !pend_req_out.valid) else $error("pend too long");
  chk_pend_in_range:
  assert property (pend_req_out.valid |-> pend_req_out.irq_number_field < 9'(NUM_IRQ))
    else $error("pend beyond lines");
  // Main scenarios reached
  cov_pend: cover property (pend_req_out.valid);
  cov_ctx: cover property (new_fp_context_in);
  cov_err: cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2);
endmodule : fpir_props

// >>> test_fpir_sysregs.sv
`timescale 1ns/1ps
module test_fpir_sysregs;
  logic clk_sys_in = 1'h0, sys_rst_in = 1'h1, new_fp_context_in = 1'h0;
  logic [11:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
  logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, auxiliary_control_out;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, s_axi_awready_out;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [8:0] pend_num = 9'h000;
  fpir_pkg::fpir_fp_modes_t fp_status_control_out;
  fpir_pkg::fpir_pend_t pend_req_out;
  int err_total = 0, checks = 0, cyc = 0, pend_cnt = 0;
  fpir_sysregs #(.FP_PRESENT(1'h1), .NUM_IRQ(64)) uut (.*);
  // 25 ns period
  always #12.5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Both write halves offered at once, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic p, logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    logic [1:0] b_r;
    s_axi_awaddr_in <= a;
    s_axi_awprot_in <= {2'h0, p};
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    // Settled handshake values taken mid-cycle, so the edge cannot race them
    do
    begin
      @(negedge clk_sys_in);
      aw_ok = s_axi_awready_out;
      w_ok = s_axi_wready_out;
      b_ok = s_axi_bvalid_out;
      b_r = s_axi_bresp_out;
      @(posedge clk_sys_in);
      if (aw_ok) s_axi_awvalid_in <= 1'h0;
      if (w_ok) s_axi_wvalid_in <= 1'h0;
    end
    while (!b_ok);
    chk("bresp", 32'(b_r), 32'(r));
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic p, logic [31:0] d, logic [1:0] r);
    logic ar_ok;
    logic r_ok;
    logic [31:0] r_d;
    logic [1:0] r_r;
    s_axi_araddr_in <= a;
    s_axi_arprot_in <= {2'h0, p};
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do
    begin
      @(negedge clk_sys_in);
      ar_ok = s_axi_arready_out;
      r_ok = s_axi_rvalid_out;
      r_d = s_axi_rdata_out;
      r_r = s_axi_rresp_out;
      @(posedge clk_sys_in);
      if (ar_ok) s_axi_arvalid_in <= 1'h0;
    end
    while (!r_ok);
    chk("rdata", r_d, d);
    chk("rresp", 32'(r_r), 32'(r));
  endtask : rd
  task automatic fpctx(input logic [4:0] e);
    new_fp_context_in <= 1'h1;
    @(posedge clk_sys_in);
    new_fp_context_in <= 1'h0;
    @(posedge clk_sys_in);
    chk("fp status", 32'(fp_status_control_out), 32'(e));
  endtask : fpctx
  task automatic s_ctx();
    wr(12'h000, 32'hFFFF_FFFF, 1'h1, 2'h0);
    wr(12'h000, 32'h0, 1'h0, 2'h2);
    rd(12'h000, 1'h0, 32'h0, 2'h2);
    rd(12'h000, 1'h1, 32'hFFFF_FFF8, 2'h0);
    rd(12'h020, 1'h1, 32'h0, 2'h2);
  endtask : s_ctx
  task automatic s_dflt();
    wr(12'h004, 32'hFFFF_FFFF, 1'h1, 2'h0);
    rd(12'h004, 1'h1, 32'h07C0_0000, 2'h0);
    fpctx(5'h1F);
    wr(12'h004, 32'h0140_0000, 1'h1, 2'h0);
    wr(12'h004, 32'h0, 1'h0, 2'h2);
    fpctx(5'h05);
  endtask : s_dflt
  task automatic s_misc();
    wr(12'h008, 32'hF, 1'h1, 2'h0);
    rd(12'h008, 1'h0, 32'h1, 2'h0);
    wr(12'h00C, 32'h1234_5678, 1'h1, 2'h0);
    rd(12'h00C, 1'h1, 32'h1234_5678, 2'h0);
    chk("aux out", auxiliary_control_out, 32'h1234_5678);
  endtask : s_misc
  // Exception numbers 21, 79, 80 and 23 less 16; 80 lies past the lines
  task automatic s_trig();
    logic [31:0] v [4] = '{32'h5, 32'h3F, 32'h40, 32'hFFFF_FE07};
    int n [4] = '{1, 1, 0, 1};
    int base;
    for (int i = 0; i < 4; i++)
    begin
      base = pend_cnt;
      wr(12'h010, v[i], 1'h0, 2'h0);
      @(posedge clk_sys_in);
      chk("pulses", 32'(pend_cnt - base), 32'(n[i]));
      if (n[i] == 1) chk("irq number", 32'(pend_num), 32'(v[i][8:0]));
    end
  endtask : s_trig
  task automatic tally_and_finish();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // Pulse tally and hang guard; mid-cycle sampling sees each pulse exactly once
  always @(negedge clk_sys_in)
  begin
    cyc++;
    if (pend_req_out.valid === 1'h1)
    begin
      pend_cnt++;
      pend_num = pend_req_out.irq_number_field;
    end
    if (cyc == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    sys_rst_in <= 1'h0;
    @(posedge clk_sys_in);
    s_ctx();
    s_dflt();
    s_misc();
    s_trig();
    tally_and_finish();
  end
endmodule : test_fpir_sysregs
bind fpir_sysregs fpir_props #(.NUM_IRQ(64)) u_props (.*);
